//--- rtl/status_bank_pkg.sv
// Package for the controller status register bank: word indices, alarm bit
// positions, own register offsets and the two input carrier structs.
// Assumes a 32-bit AHB-Lite slave with each 16-bit word in its own aligned word.
package status_bank_pkg;

  // Printed word indices; byte address is four times the index
  localparam logic [15:0] IDX_ALARM_SUMMARY = 16'h3800;
  localparam logic [15:0] IDX_DISCRETE_OUTPUT_STATE = 16'h3801;
  localparam logic [15:0] IDX_DISCRETE_INPUT_STATE = 16'h3802;
  localparam logic [15:0] IDX_RUN_STATE = 16'h3810;
  localparam logic [15:0] IDX_AUTO_MANUAL_STATE = 16'h3811;
  localparam logic [15:0] IDX_AUTOTUNE_STATE = 16'h3812;
  localparam logic [15:0] IDX_RESERVED_STATUS_A = 16'h3813;
  localparam logic [15:0] IDX_PROCESS_VALUE = 16'h3814;
  localparam logic [15:0] IDX_TARGET_VALUE = 16'h3815;
  localparam logic [15:0] IDX_OUTPUT_VALUE = 16'h3816;
  localparam logic [15:0] IDX_RESERVED_STATUS_B = 16'h3850;
  localparam logic [15:0] IDX_RESERVED_STATUS_C = 16'h3851;
  localparam logic [15:0] IDX_LOAD_CURRENT_FIRST = 16'h3852;
  localparam logic [15:0] IDX_LOAD_CURRENT_SECOND = 16'h3853;
  localparam logic [15:0] IDX_HEATING_OUTPUT = 16'h3854;
  localparam logic [15:0] IDX_COOLING_OUTPUT = 16'h3855;

  // EEPROM-space copy sits this far above the RAM index
  localparam logic [15:0] IDX_EEPROM_OFFSET = 16'h4000;

  // Interrupt registers (word indices)
  localparam logic [15:0] IDX_IRQ_STATUS = 16'h3F00;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h3F01;

  // Alarm summary bit positions
  localparam int BIT_PV_ERROR = 0;
  localparam int BIT_CT_ERROR = 2;
  localparam int BIT_INIT_ERROR = 8;
  localparam int BIT_AD_ERROR = 12;
  localparam int BIT_SETTING_ERROR = 13;
  localparam int BIT_ADJUST_ERROR = 14;
  localparam logic [15:0] ALARM_DEFINED_MASK = 16'h7105;

  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] RESERVED_READ = 16'h0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HRESP_OKAY = 2'b00;
  localparam int ADDR_LSB = 2;

  // Error causes from the controller core
  typedef struct packed {
    logic adjust_error;
    logic setting_error;
    logic ad_error;
    logic init_error;
    logic ct_error;
    logic pv_error;
  } alarm_causes_t;

  // Live operating values from the controller core
  typedef struct packed {
    logic [15:0] do_word_9205;
    logic [15:0] di_word_9206;
    logic [15:0] run_state;
    logic [15:0] auto_manual_state;
    logic [15:0] autotune_state;
    logic [15:0] process_value;
    logic [15:0] target_value;
    logic [15:0] output_value;
    logic [15:0] ct1_word_9110;
    logic [15:0] ct2_word_9111;
    logic [15:0] heat_word_9106;
    logic [15:0] cool_word_9107;
  } process_words_t;

endpackage : status_bank_pkg

//--- rtl/status_bank.sv
// Status bank of a single-loop controller on AHB-Lite; read-only except the interrupt status and mask registers.
// Assumes one master, single word transfers, inputs synchronous to clk_sys.
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module status_bank
  import status_bank_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire alarm_causes_t alarm_causes,
  input wire process_words_t process_words,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Snapshot of live words, so a read returns one coherent value

  logic [15:0] alarm_q, alarm_d;
  process_words_t words_q, words_d;

  always_comb begin
    alarm_d = WORD_RESET;
    alarm_d[BIT_PV_ERROR] = alarm_causes.pv_error;
    alarm_d[BIT_CT_ERROR] = alarm_causes.ct_error;
    alarm_d[BIT_INIT_ERROR] = alarm_causes.init_error;
    alarm_d[BIT_AD_ERROR] = alarm_causes.ad_error;
    alarm_d[BIT_SETTING_ERROR] = alarm_causes.setting_error;
    alarm_d[BIT_ADJUST_ERROR] = alarm_causes.adjust_error;
    alarm_d = alarm_d & ALARM_DEFINED_MASK;
    words_d = process_words;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      alarm_q <= WORD_RESET;
      words_q <= '0;
    end else if (clk_en) begin
      alarm_q <= alarm_d;
      words_q <= words_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: a rising alarm bit sets a sticky status bit

  logic [15:0] irq_status_q, irq_status_d;
  logic [15:0] irq_mask_q, irq_mask_d;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite address phase capture; data phase answers next cycle, no waits

  logic wr_pend_q, wr_pend_d;
  logic rd_pend_q, rd_pend_d;
  logic [15:0] idx_q, idx_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic [15:0] addr_idx;
  logic [15:0] ram_idx;
  logic take;
  logic [15:0] rd_word;

  assign addr_idx = haddr[ADDR_LSB +: 16];
  assign take = hsel && hready && htrans[1];

  // Fold EEPROM space onto RAM space
  always_comb begin
    ram_idx = addr_idx;
    if (addr_idx >= IDX_EEPROM_OFFSET) begin
      ram_idx = addr_idx - IDX_EEPROM_OFFSET;
    end
  end

  always_comb begin
    case (ram_idx)
      IDX_ALARM_SUMMARY: rd_word = alarm_q;
      IDX_DISCRETE_OUTPUT_STATE: rd_word = words_q.do_word_9205;
      IDX_DISCRETE_INPUT_STATE: rd_word = words_q.di_word_9206;
      IDX_RUN_STATE: rd_word = words_q.run_state;
      IDX_AUTO_MANUAL_STATE: rd_word = words_q.auto_manual_state;
      IDX_AUTOTUNE_STATE: rd_word = words_q.autotune_state;
      IDX_PROCESS_VALUE: rd_word = words_q.process_value;
      IDX_TARGET_VALUE: rd_word = words_q.target_value;
      IDX_OUTPUT_VALUE: rd_word = words_q.output_value;
      IDX_LOAD_CURRENT_FIRST: rd_word = words_q.ct1_word_9110;
      IDX_LOAD_CURRENT_SECOND: rd_word = words_q.ct2_word_9111;
      IDX_HEATING_OUTPUT: rd_word = words_q.heat_word_9106;
      IDX_COOLING_OUTPUT: rd_word = words_q.cool_word_9107;
      IDX_IRQ_STATUS: rd_word = irq_status_q;
      IDX_IRQ_MASK: rd_word = irq_mask_q;
      default: rd_word = RESERVED_READ;
    endcase
  end

  always_comb begin
    wr_pend_d = take && hwrite;
    rd_pend_d = take && !hwrite;
    idx_d = take ? addr_idx : idx_q;
    hrdata_d = hrdata_q;
    if (take && !hwrite) begin
      hrdata_d = {16'h0000, rd_word};
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q <= 16'h0000;
      hrdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      wr_pend_q <= wr_pend_d;
      rd_pend_q <= rd_pend_d;
      idx_q <= idx_d;
      hrdata_q <= hrdata_d;
    end
  end

  // Only the interrupt registers accept data; status words drop writes
  logic wr_status;
  logic wr_mask;
  assign wr_status = wr_pend_q && (idx_q == IDX_IRQ_STATUS);
  assign wr_mask = wr_pend_q && (idx_q == IDX_IRQ_MASK);

  always_comb begin
    irq_mask_d = irq_mask_q;
    if (wr_mask) begin
      irq_mask_d = hwdata[15:0];
    end
    irq_status_d = irq_status_q;
    if (wr_status) begin
      irq_status_d = irq_status_q & ~hwdata[15:0];
    end
    // New events win over a simultaneous clear
    irq_status_d = irq_status_d | (alarm_d & ~alarm_q);
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_status_q <= WORD_RESET;
      irq_mask_q <= WORD_RESET;
    end else if (clk_en) begin
      irq_status_q <= irq_status_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);
  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY[0];

endmodule : status_bank

`default_nettype wire

//--- bench/status_bank_properties.sv
// Checker for status_bank: read data tied to the live inputs, bus answer.
// Assumes inputs move only just after rising edges of clk_sys.
`timescale 1ns/1ps
`default_nettype none
module status_bank_properties import status_bank_pkg::*; #(parameter int ADDR_W = 32) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire alarm_causes_t alarm_causes,
  input wire process_words_t process_words
);
  wire process_words_t p = process_words;
  wire [5:0] a = alarm_causes;
  wire [15:0] amap = {1'b0, a[5:3], 3'h0, a[2], 5'h0, a[1], 1'b0, a[0]};
  // EEPROM-space index folded onto RAM, so every mirror check covers both spaces
  wire [15:0] idx = haddr[17:2] & 16'hBFFF;
  logic [197:0] ins_q;
  logic en_q;
  always_ff @(posedge clk_sys) ins_q <= {a, p};
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) en_q <= 1'b0;
    else en_q <= clk_en;
  end
  // Only judge reads whose snapshot edge saw the same inputs; skips the snapshot race
  wire go = hsel && hready && htrans[1] && clk_en && !hwrite && en_q && {a, p} == ins_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  alarm_word_a: assert property (go && idx == IDX_ALARM_SUMMARY
    |=> hrdata == {16'h0, $past(amap)}) else $error("alarm word");
  do_word_a: assert property (go && idx == IDX_DISCRETE_OUTPUT_STATE
    |=> hrdata == {16'h0, $past(p.do_word_9205)}) else $error("do word");
  di_word_a: assert property (go && idx == IDX_DISCRETE_INPUT_STATE
    |=> hrdata == {16'h0, $past(p.di_word_9206)}) else $error("di word");
  ct_first_a: assert property (go && idx == IDX_LOAD_CURRENT_FIRST
    |=> hrdata == {16'h0, $past(p.ct1_word_9110)}) else $error("ct1 word");
  ct_second_a: assert property (go && idx == IDX_LOAD_CURRENT_SECOND
    |=> hrdata == {16'h0, $past(p.ct2_word_9111)}) else $error("ct2 word");
  heat_word_a: assert property (go && idx == IDX_HEATING_OUTPUT
    |=> hrdata == {16'h0, $past(p.heat_word_9106)}) else $error("heat word");
  cool_word_a: assert property (go && idx == IDX_COOLING_OUTPUT
    |=> hrdata == {16'h0, $past(p.cool_word_9107)}) else $error("cool word");
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer");
endmodule : status_bank_properties
bind status_bank status_bank_properties #(.ADDR_W(ADDR_W)) props (.*);
`default_nettype wire

//--- bench/controller_status_register_map_test.sv
// Self-checking bench for status_bank, driving AHB-Lite as the only master.
// Assumes hready is looped back from hreadyout and clk_en stays high.
`timescale 1ns/1ps
`default_nettype none
module controller_status_register_map_test import status_bank_pkg::*;;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  alarm_causes_t alarm_causes = '0;
  process_words_t process_words = '0;
  int fail_count = 0;
  int n_compared = 0;
  always #50 clk_sys = ~clk_sys;
  status_bank uut (.clk_sys(clk_sys), .reset(reset), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .alarm_causes(alarm_causes),
    .process_words(process_words), .irq(irq));
  task automatic final_report;
    if (fail_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
      output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {14'h0, idx, 2'h0};
    // Address phase, then data phase; each waits for hready
    for (int ph = 0; ph < 2; ph++) begin
      for (int n = 0; n < 20; n++) begin
        @(posedge clk_sys);
        if (hreadyout === 1'b1) break;
        if (n == 19) begin
          fail_count++;
          final_report();
        end
      end
      // Release only after the address phase; the next call may raise hsel again
      if (ph == 0) begin
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
      end
    end
    rd = hrdata;
  endtask : xfer
  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, idx, 32'h0, r);
    chk(r, exp);
  endtask : rd_chk
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, idx, d, r);
  endtask : wr
  task automatic alarm_bits;
    int pos[6] = '{BIT_PV_ERROR, BIT_CT_ERROR, BIT_INIT_ERROR, BIT_AD_ERROR,
      BIT_SETTING_ERROR, BIT_ADJUST_ERROR};
    for (int i = 0; i < 6; i++) begin
      alarm_causes <= alarm_causes_t'(6'h1 << i);
      repeat (2) @(posedge clk_sys);
      rd_chk(IDX_ALARM_SUMMARY, 32'h1 << pos[i]);
      rd_chk(IDX_ALARM_SUMMARY + IDX_EEPROM_OFFSET, 32'h1 << pos[i]);
    end
  endtask : alarm_bits
  task automatic mirrors;
    logic [15:0] idx[12] = '{IDX_DISCRETE_OUTPUT_STATE, IDX_DISCRETE_INPUT_STATE, IDX_RUN_STATE,
      IDX_AUTO_MANUAL_STATE, IDX_AUTOTUNE_STATE, IDX_PROCESS_VALUE, IDX_TARGET_VALUE,
      IDX_OUTPUT_VALUE, IDX_LOAD_CURRENT_FIRST, IDX_LOAD_CURRENT_SECOND, IDX_HEATING_OUTPUT,
      IDX_COOLING_OUTPUT};
    logic [191:0] v;
    for (int k = 0; k < 12; k++) v[191 - 16 * k -: 16] = 16'(16'h1111 * (k + 1));
    process_words <= v;
    repeat (2) @(posedge clk_sys);
    for (int k = 0; k < 12; k++) begin
      rd_chk(idx[k], {16'h0, v[191 - 16 * k -: 16]});
      rd_chk(idx[k] + IDX_EEPROM_OFFSET, {16'h0, v[191 - 16 * k -: 16]});
    end
  endtask : mirrors
  task automatic write_refused;
    wr(IDX_PROCESS_VALUE, 32'hFFFF);
    wr(IDX_DISCRETE_OUTPUT_STATE + IDX_EEPROM_OFFSET, 32'hFFFF);
    rd_chk(IDX_PROCESS_VALUE, 32'h6666);
    rd_chk(IDX_DISCRETE_OUTPUT_STATE, 32'h1111);
    rd_chk(16'h3900, 32'h0);
  endtask : write_refused
  task automatic interrupt;
    alarm_causes <= '0;
    repeat (2) @(posedge clk_sys);
    wr(IDX_IRQ_STATUS, 32'hFFFF);
    wr(IDX_IRQ_MASK, 32'h0004);
    alarm_causes <= 6'h01;
    repeat (3) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    alarm_causes <= 6'h03;
    repeat (3) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    rd_chk(IDX_IRQ_STATUS, 32'h0005);
    wr(IDX_IRQ_STATUS, 32'h0004);
    @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    rd_chk(IDX_IRQ_STATUS, 32'h0001);
  endtask : interrupt
  initial begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    alarm_bits();
    mirrors();
    write_refused();
    interrupt();
    final_report();
  end
endmodule : controller_status_register_map_test
`default_nettype wire
